// ### core/epc_pkg.sv
// shared constants and types for the enciphered pin / cryptogram terminal controller
// assumes byte-wide command and response links to the card and rsa engine, and a 64-bit block link to the tdes engine
package epc_pkg;
  localparam logic [7:0] HDR_BYTE = 8'h7F;
  localparam int PIN_BLOCK_BYTES = 8;
  localparam int CHAL_BYTES = 8;
  localparam int PAD_OVERHEAD = 17;
  localparam int SW_BYTES = 2;
  localparam int TAIL_BYTES = 10;
  localparam int CRYPTO_BYTES = 8;
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [11:0] SW_RETRY_HI = 12'h63C;
  localparam logic [15:0] TAG_PE_CERT = 16'h9F2D;
  localparam logic [15:0] TAG_PE_EXP = 16'h9F2E;
  localparam logic [15:0] TAG_PE_REM = 16'h9F2F;
  localparam logic [7:0] CLA_PLAIN = 8'h00;
  localparam logic [7:0] CLA_PROP = 8'h80;
  localparam logic [7:0] INS_CHALLENGE = 8'h84;
  localparam logic [7:0] INS_VERIFY = 8'h20;
  localparam logic [7:0] INS_GENERATE = 8'hAE;
  localparam logic [7:0] P1_ZERO = 8'h00;
  localparam logic [7:0] P1_GEN_REQ = 8'h40;
  localparam logic [7:0] P2_ENC_PIN = 8'h88;
  localparam logic [7:0] HDR_LEN = 8'h05;
  localparam logic [7:0] CHAL_LEN = 8'h08;
  localparam logic [7:0] GEN_DATA_LEN = 8'h1D;
  localparam int GEN_DATA_BYTES = 29;
  localparam logic [7:0] MIN_MOD_LEN = 8'h11;
  localparam logic [1:0] KEY_PIN_ENC = 2'h1;
  localparam logic [1:0] KEY_DYN_AUTH = 2'h2;
  localparam logic [1:0] KEY_NONE = 2'h0;

  typedef enum logic [3:0] {
    S_IDLE, S_CH_CMD, S_CH_RSP, S_VF_HDR, S_VF_FWD, S_VF_RSP,
    S_GEN_CMD, S_GEN_RSP, S_ARC_RUN
  } epc_state_t;
endpackage

// ### core/epc_rsp_collect.sv
// response collector: counts bytes of one card response and keeps its last ten bytes
// assumes rspValid is a one-cycle strobe per byte and rspLast marks the final status byte
`timescale 1ns/100ps
`default_nettype none
module epc_rsp_collect (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic rspValid,
  input wire logic [7:0] rspByte,
  input wire logic rspLast,
  output logic done,
  output logic [7:0] count,
  output logic [79:0] tail
);
  typedef struct packed {
    logic done;
    logic [7:0] count;
    logic [79:0] tail;
  } epc_coll_t;

  epc_coll_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (clear) begin
      s_d.count = 8'h00;
      s_d.tail = '0;
    end
    // a byte in the clear cycle opens the new response, cards may answer at once
    if (rspValid) begin
      // saturate so a runaway response cannot wrap into a legal length
      if (s_d.count != 8'hFF) s_d.count = s_d.count + 8'h01;
      s_d.tail = {s_d.tail[71:0], rspByte};
      s_d.done = rspLast;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) s_q <= '0;
    else s_q <= s_d;
  end

  assign done = s_q.done;
  assign count = s_q.count;
  assign tail = s_q.tail;
endmodule
`default_nettype wire

// ### core/epc_block_src.sv
// plaintext block source feeding the secure encipherment engine byte by byte
// assumes the engine takes a byte when inReady is high with inValid, and rng bytes are fresh
`timescale 1ns/100ps
`default_nettype none
module epc_block_src (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [7:0] modLen,
  input wire logic [63:0] pinBlock,
  input wire logic [63:0] challenge,
  input wire logic rngValid,
  input wire logic [7:0] rngByte,
  output logic rngTake,
  output logic inValid,
  output logic [7:0] inByte,
  output logic inLast,
  input wire logic inReady
);
  typedef struct packed {
    logic busy;
    logic [7:0] idx;
    logic valid;
    logic [7:0] data;
    logic last;
    logic take;
  } epc_blk_t;

  localparam logic [7:0] PIN_END = 8'(1 + epc_pkg::PIN_BLOCK_BYTES);
  localparam logic [7:0] CHAL_END = 8'(1 + epc_pkg::PIN_BLOCK_BYTES + epc_pkg::CHAL_BYTES);

  epc_blk_t s_q, s_d;

  function automatic logic [7:0] pick(input logic [63:0] v, input logic [7:0] i);
    pick = v[8'(63) - {i[2:0], 3'b000} -: 8];
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.take = 1'b0;
    if (start) begin
      s_d.busy = 1'b1;
      s_d.idx = 8'h00;
      s_d.valid = 1'b0;
    end else if (s_q.valid) begin
      if (inReady) begin
        s_d.valid = 1'b0;
        s_d.busy = !s_q.last;
      end
    end else if (s_q.busy) begin
      // header, pin block, challenge, then modLen-17 pad bytes
      s_d.last = (s_q.idx == modLen - 8'h01);
      if (s_q.idx == 8'h00) begin
        s_d.data = epc_pkg::HDR_BYTE;
        s_d.valid = 1'b1;
      end else if (s_q.idx < PIN_END) begin
        s_d.data = pick(pinBlock, s_q.idx - 8'h01);
        s_d.valid = 1'b1;
      end else if (s_q.idx < CHAL_END) begin
        s_d.data = pick(challenge, s_q.idx - PIN_END);
        s_d.valid = 1'b1;
      end else if (rngValid) begin
        s_d.data = rngByte;
        s_d.valid = 1'b1;
        s_d.take = 1'b1;
      end
      if (s_d.valid) s_d.idx = s_q.idx + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) s_q <= '0;
    else s_q <= s_d;
  end

  assign rngTake = s_q.take;
  assign inValid = s_q.valid;
  assign inByte = s_q.data;
  assign inLast = s_q.last;
endmodule
`default_nettype wire

// ### core/epc_terminal_ctrl.sv
// terminal-side controller: enciphered pin exchange and cryptogram handling with a card
// assumes byte links to the card and an external secure rsa engine, and a 64-bit block link to a triple-des engine
// Behaviour
// - use pin key if its objects all present, else auth key, else fail
// - pin key objects carry tags 9F2D, 9F2E, 9F2F; remainder optional
// - fetch challenge; anything but 8 bytes with 9000 fails the method
// - random pad length is modulus bytes minus 17
// - block is 7F header, pin block, challenge, pad, in that order
// - send the enciphered block in a verify command
// - failure answers 63Cx; a retry restarts from pin entry
// - padding and encipherment happen in a secure component; here epc_block_src adds the pad, only encipherment is in the engine
// - cryptogram input is terminal data from the command plus card data
// - terminal sends amounts, codes, results, date, type, number
// - response cryptogram is triple-des of request cryptogram and code
// - pad code with six zero bytes, xor with request cryptogram, encrypt
`timescale 1ns/100ps
`default_nettype none
module epc_terminal_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pinStart,
  input wire logic [63:0] pinBlock,
  input wire logic peCertSeen,
  input wire logic peExpSeen,
  input wire logic peRemNeeded,
  input wire logic peRemSeen,
  input wire logic [7:0] peModLen,
  input wire logic dynKeySeen,
  input wire logic [7:0] dynModLen,
  output logic pinDone,
  output logic pinPass,
  output logic [3:0] triesLeft,
  output logic [1:0] keySel,
  input wire logic genStart,
  input wire logic [231:0] genData,
  output logic genDone,
  output logic genOk,
  output logic [63:0] requestCryptogram,
  input wire logic arcStart,
  input wire logic [15:0] responseCode,
  output logic arcDone,
  output logic [63:0] responseCryptogram,
  output logic cmdValid,
  output logic [7:0] cmdByte,
  output logic cmdLast,
  input wire logic cmdReady,
  input wire logic rspValid,
  input wire logic [7:0] rspByte,
  input wire logic rspLast,
  input wire logic rngValid,
  input wire logic [7:0] rngByte,
  output logic rngTake,
  output logic rsaInValid,
  output logic [7:0] rsaInByte,
  output logic rsaInLast,
  input wire logic rsaInReady,
  input wire logic rsaOutValid,
  input wire logic [7:0] rsaOutByte,
  input wire logic rsaOutLast,
  output logic rsaOutReady,
  output logic tdesValid,
  output logic [63:0] tdesBlock,
  input wire logic tdesDone,
  input wire logic [63:0] tdesResult
);
  typedef struct packed {
    epc_pkg::epc_state_t st;
    logic [7:0] idx;
    logic cmdValid;
    logic [7:0] cmdByte;
    logic cmdLast;
    logic rsaOutReady;
    logic [1:0] keySel;
    logic [7:0] modLen;
    logic [63:0] challenge;
    logic pinDone;
    logic pinPass;
    logic [3:0] triesLeft;
    logic genDone;
    logic genOk;
    logic [63:0] reqCrypto;
    logic arcDone;
    logic [63:0] rspCrypto;
    logic tdesValid;
    logic [63:0] tdesBlock;
    logic blkStart;
    logic collClr;
  } epc_ctrl_t;

  localparam logic [7:0] GEN_LAST = 8'(4 + epc_pkg::GEN_DATA_BYTES);
  localparam logic [7:0] CHAL_RSP_LEN = 8'(epc_pkg::CHAL_BYTES + epc_pkg::SW_BYTES);
  localparam logic [7:0] GEN_RSP_MIN = 8'(epc_pkg::CRYPTO_BYTES + epc_pkg::SW_BYTES);

  epc_ctrl_t s_q, s_d;
  logic collDone;
  logic [7:0] collCount;
  logic [79:0] collTail;
  logic [15:0] sw;
  logic peKeyReady;

  // five-byte command header shared by all three commands
  function automatic logic [7:0] hdrByte(input logic [7:0] cla, input logic [7:0] ins,
                                         input logic [7:0] p1, input logic [7:0] p2,
                                         input logic [7:0] len, input logic [7:0] i);
    case (i)
      8'h00: hdrByte = cla;
      8'h01: hdrByte = ins;
      8'h02: hdrByte = p1;
      8'h03: hdrByte = p2;
      default: hdrByte = len;
    endcase
  endfunction

  epc_rsp_collect u_coll (
    .clk(clk),
    .reset_n(reset_n),
    .clear(s_q.collClr),
    .rspValid(rspValid),
    .rspByte(rspByte),
    .rspLast(rspLast),
    .done(collDone),
    .count(collCount),
    .tail(collTail)
  );

  // kept outside the card link: the pad is added here from rng bytes, only encipherment is in the secure engine
  epc_block_src u_blk (
    .clk(clk),
    .reset_n(reset_n),
    .start(s_q.blkStart),
    .modLen(s_q.modLen),
    .pinBlock(pinBlock),
    .challenge(s_q.challenge),
    .rngValid(rngValid),
    .rngByte(rngByte),
    .rngTake(rngTake),
    .inValid(rsaInValid),
    .inByte(rsaInByte),
    .inLast(rsaInLast),
    .inReady(rsaInReady)
  );

  assign sw = collTail[15:0];
  // remainder object only matters when the key overflows its certificate
  assign peKeyReady = peCertSeen && peExpSeen && (!peRemNeeded || peRemSeen);

  always_comb begin
    s_d = s_q;
    s_d.pinDone = 1'b0;
    s_d.genDone = 1'b0;
    s_d.arcDone = 1'b0;
    s_d.blkStart = 1'b0;
    s_d.collClr = 1'b0;
    s_d.rsaOutReady = 1'b0;
    case (s_q.st)
      epc_pkg::S_IDLE: begin
        s_d.idx = 8'h00;
        if (pinStart) begin
          s_d.pinPass = 1'b0;
          // key choice with fallback, too-short modulus cannot hold the block
          if (peKeyReady && peModLen >= epc_pkg::MIN_MOD_LEN) begin
            s_d.keySel = epc_pkg::KEY_PIN_ENC;
            s_d.modLen = peModLen;
            s_d.st = epc_pkg::S_CH_CMD;
          end else if (dynKeySeen && dynModLen >= epc_pkg::MIN_MOD_LEN) begin
            s_d.keySel = epc_pkg::KEY_DYN_AUTH;
            s_d.modLen = dynModLen;
            s_d.st = epc_pkg::S_CH_CMD;
          end else begin
            s_d.keySel = epc_pkg::KEY_NONE;
            s_d.pinDone = 1'b1;
          end
        end else if (genStart) begin
          s_d.st = epc_pkg::S_GEN_CMD;
        end else if (arcStart) begin
          // code padded with six zero bytes then xored with request cryptogram
          s_d.tdesBlock = {responseCode, 48'h0} ^ s_q.reqCrypto;
          s_d.tdesValid = 1'b1;
          s_d.st = epc_pkg::S_ARC_RUN;
        end
      end
      epc_pkg::S_CH_CMD: begin
        if (!s_q.cmdValid) begin
          // challenge request for eight bytes
          s_d.cmdByte = hdrByte(epc_pkg::CLA_PLAIN, epc_pkg::INS_CHALLENGE, epc_pkg::P1_ZERO,
                                epc_pkg::P1_ZERO, epc_pkg::CHAL_LEN, s_q.idx);
          s_d.cmdLast = (s_q.idx == epc_pkg::HDR_LEN - 8'h01);
          s_d.cmdValid = 1'b1;
        end else if (cmdReady) begin
          s_d.cmdValid = 1'b0;
          s_d.idx = s_q.idx + 8'h01;
          if (s_q.cmdLast) begin
            s_d.collClr = 1'b1;
            s_d.st = epc_pkg::S_CH_RSP;
          end
        end
      end
      epc_pkg::S_CH_RSP: begin
        s_d.idx = 8'h00;
        if (collDone) begin
          // exact length and success status or the method fails
          if (collCount == CHAL_RSP_LEN && sw == epc_pkg::SW_OK) begin
            s_d.challenge = collTail[79:16];
            s_d.blkStart = 1'b1;
            s_d.st = epc_pkg::S_VF_HDR;
          end else begin
            s_d.pinDone = 1'b1;
            s_d.st = epc_pkg::S_IDLE;
          end
        end
      end
      epc_pkg::S_VF_HDR: begin
        if (!s_q.cmdValid) begin
          // verify header, length equals modulus size
          s_d.cmdByte = hdrByte(epc_pkg::CLA_PLAIN, epc_pkg::INS_VERIFY, epc_pkg::P1_ZERO,
                                epc_pkg::P2_ENC_PIN, s_q.modLen, s_q.idx);
          s_d.cmdLast = 1'b0;
          s_d.cmdValid = 1'b1;
        end else if (cmdReady) begin
          s_d.cmdValid = 1'b0;
          s_d.idx = s_q.idx + 8'h01;
          if (s_q.idx == epc_pkg::HDR_LEN - 8'h01) s_d.st = epc_pkg::S_VF_FWD;
        end
      end
      epc_pkg::S_VF_FWD: begin
        // enciphered bytes pass straight to the card; card stalls the engine
        if (!s_q.cmdValid) begin
          if (rsaOutValid && !s_q.rsaOutReady) begin
            s_d.cmdByte = rsaOutByte;
            s_d.cmdLast = rsaOutLast;
            s_d.cmdValid = 1'b1;
            s_d.rsaOutReady = 1'b1;
          end
        end else if (cmdReady) begin
          s_d.cmdValid = 1'b0;
          if (s_q.cmdLast) begin
            s_d.collClr = 1'b1;
            s_d.st = epc_pkg::S_VF_RSP;
          end
        end
      end
      epc_pkg::S_VF_RSP: begin
        if (collDone) begin
          s_d.pinDone = 1'b1;
          s_d.st = epc_pkg::S_IDLE;
          // pass only on a clean success status from the card
          s_d.pinPass = (collCount == 8'(epc_pkg::SW_BYTES) && sw == epc_pkg::SW_OK);
          // retry count from 63Cx; a new attempt needs a fresh pinStart
          if (sw[15:4] == epc_pkg::SW_RETRY_HI) s_d.triesLeft = sw[3:0];
        end
      end
      epc_pkg::S_GEN_CMD: begin
        if (!s_q.cmdValid) begin
          // terminal items streamed after the header, card adds its own
          if (s_q.idx < epc_pkg::HDR_LEN)
            s_d.cmdByte = hdrByte(epc_pkg::CLA_PROP, epc_pkg::INS_GENERATE, epc_pkg::P1_GEN_REQ,
                                  epc_pkg::P1_ZERO, epc_pkg::GEN_DATA_LEN, s_q.idx);
          else
            s_d.cmdByte = genData[8'(231) - {s_q.idx - epc_pkg::HDR_LEN, 3'b000} -: 8];
          s_d.cmdLast = (s_q.idx == GEN_LAST);
          s_d.cmdValid = 1'b1;
        end else if (cmdReady) begin
          s_d.cmdValid = 1'b0;
          s_d.idx = s_q.idx + 8'h01;
          if (s_q.cmdLast) begin
            s_d.collClr = 1'b1;
            s_d.st = epc_pkg::S_GEN_RSP;
          end
        end
      end
      epc_pkg::S_GEN_RSP: begin
        s_d.idx = 8'h00;
        if (collDone) begin
          // last eight data bytes before status are the request cryptogram
          s_d.genOk = (collCount >= GEN_RSP_MIN && sw == epc_pkg::SW_OK);
          if (s_d.genOk) s_d.reqCrypto = collTail[79:16];
          s_d.genDone = 1'b1;
          s_d.st = epc_pkg::S_IDLE;
        end
      end
      epc_pkg::S_ARC_RUN: begin
        // triple-des under the session key held by the engine
        if (tdesDone) begin
          s_d.tdesValid = 1'b0;
          s_d.rspCrypto = tdesResult;
          s_d.arcDone = 1'b1;
          s_d.st = epc_pkg::S_IDLE;
        end
      end
      default: begin
        s_d.st = epc_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) s_q <= '0;
    else s_q <= s_d;
  end

  assign pinDone = s_q.pinDone;
  assign pinPass = s_q.pinPass;
  assign triesLeft = s_q.triesLeft;
  assign keySel = s_q.keySel;
  assign genDone = s_q.genDone;
  assign genOk = s_q.genOk;
  assign requestCryptogram = s_q.reqCrypto;
  assign arcDone = s_q.arcDone;
  assign responseCryptogram = s_q.rspCrypto;
  assign cmdValid = s_q.cmdValid;
  assign cmdByte = s_q.cmdByte;
  assign cmdLast = s_q.cmdLast;
  assign rsaOutReady = s_q.rsaOutReady;
  assign tdesValid = s_q.tdesValid;
  assign tdesBlock = s_q.tdesBlock;
endmodule
`default_nettype wire

// ### bench/epc_checker.sv
// port-level assertions for the terminal controller
// assumes the bench holds key inputs and responseCode steady during a request
`timescale 1ns/100ps
`default_nettype none
module epc_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic peCertSeen,
  input wire logic peExpSeen,
  input wire logic peRemNeeded,
  input wire logic peRemSeen,
  input wire logic [7:0] peModLen,
  input wire logic [7:0] dynModLen,
  input wire logic pinDone,
  input wire logic pinPass,
  input wire logic [1:0] keySel,
  input wire logic genDone,
  input wire logic [15:0] responseCode,
  input wire logic [63:0] requestCryptogram,
  input wire logic arcDone,
  input wire logic [63:0] responseCryptogram,
  input wire logic cmdValid,
  input wire logic [7:0] cmdByte,
  input wire logic cmdLast,
  input wire logic cmdReady,
  input wire logic rngValid,
  input wire logic rngTake,
  input wire logic rsaInValid,
  input wire logic [7:0] rsaInByte,
  input wire logic rsaInLast,
  input wire logic rsaInReady,
  input wire logic tdesValid,
  input wire logic [63:0] tdesBlock,
  input wire logic tdesDone,
  input wire logic [63:0] tdesResult
);
  logic [7:0] rsaCnt_q;
  logic peOk;
  // pin key needs every object, remainder only when one exists
  assign peOk = peCertSeen && peExpSeen && (!peRemNeeded || peRemSeen) && peModLen >= 8'h11;
  always_ff @(posedge clk) begin
    if (!reset_n || (rsaInValid && rsaInReady && rsaInLast))
      rsaCnt_q <= 8'h00;
    else if (rsaInValid && rsaInReady)
      rsaCnt_q <= rsaCnt_q + 8'h01;
  end
  // no disable here: it checks the reset itself
  a_reset_quiet: assert property (@(posedge clk) !reset_n |=>
    !cmdValid && !pinDone && !pinPass && !rsaInValid && !tdesValid)
    else $error("outputs active after reset");
  a_done_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    (pinDone || genDone) |=> !pinDone && !genDone) else $error("done longer than one cycle");
  a_cmd_hold: assert property (@(posedge clk) disable iff (!reset_n) cmdValid && !cmdReady |=>
    cmdValid && $stable(cmdByte) && $stable(cmdLast)) else $error("card byte dropped");
  a_cmd_gap: assert property (@(posedge clk) disable iff (!reset_n)
    cmdValid && cmdReady |=> !cmdValid) else $error("no gap after card byte");
  a_rsa_len: assert property (@(posedge clk) disable iff (!reset_n)
    rsaInValid && rsaInReady && rsaInLast |-> rsaCnt_q + 8'h01 == (peOk ? peModLen : dynModLen))
    else $error("block length wrong");
  a_hdr_first: assert property (@(posedge clk) disable iff (!reset_n)
    rsaInValid && rsaCnt_q == 8'h00 |-> rsaInByte == epc_pkg::HDR_BYTE)
    else $error("block header wrong");
  a_rng_take: assert property (@(posedge clk) disable iff (!reset_n)
    rngTake |-> $past(rngValid)) else $error("pad byte taken while not valid");
  a_key_none: assert property (@(posedge clk) disable iff (!reset_n)
    pinDone && keySel == epc_pkg::KEY_NONE |-> !pinPass) else $error("pass with no key");
  a_tdes_block: assert property (@(posedge clk) disable iff (!reset_n)
    tdesValid |-> tdesBlock == ({responseCode, 48'h0} ^ requestCryptogram))
    else $error("tdes block wrong");
  a_arc_done: assert property (@(posedge clk) disable iff (!reset_n)
    tdesValid && tdesDone |=> arcDone && responseCryptogram == $past(tdesResult))
    else $error("response cryptogram wrong");
endmodule
bind epc_terminal_ctrl epc_checker u_epc_checker (.*);
`default_nettype wire

// ### bench/epc_card_model.sv
// card model: answers challenge, verify and generate commands
// assumes the bench rsa engine is a loopback, so decryption is identity
`timescale 1ns/100ps
`default_nettype none
module epc_card_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cmdValid,
  input wire logic [7:0] cmdByte,
  input wire logic cmdLast,
  output logic cmdReady,
  output logic rspValid,
  output logic [7:0] rspByte,
  output logic rspLast,
  input wire logic [63:0] refPin,
  input wire logic shortChal,
  output logic cmdErr
);
  logic [7:0] cb [0:63];
  logic [7:0] rq [$];
  logic [63:0] chal = 64'h0;
  logic [15:0] txnCnt;
  logic [3:0] tries;
  logic ok;
  int n;
  int cyc = 0;
  initial {cmdReady, rspValid, rspByte, rspLast, cmdErr} = '0;
  always @(posedge clk) begin
    #0.5;
    cyc = cyc + 1;
    cmdReady = (cyc % 3) != 0;  // stall every third cycle
    rspValid = rq.size() > 0;
    if (rspValid) begin
      rspByte = rq.pop_front();
      rspLast = rq.size() == 0;
    end else
      rspByte = ~rspByte;  // idle line toggles, showing the last byte again every second idle cycle
  end
  always @(posedge clk) begin
    if (!reset_n) begin
      n = 0;
      rq.delete();
      tries = 4'h3;
      txnCnt = 16'h0000;
    end else if (cmdValid && cmdReady) begin
      cb[n] = cmdByte;
      n = n + 1;
      if (cmdLast) begin
        // a challenge request carries only its expected length
        if (n > 5 && cb[4] != 8'(n - 5))
          cmdErr = 1'b1;
        case (cb[1])
          epc_pkg::INS_CHALLENGE: begin
            chal = chal + 64'h0123456789ABCDEF;  // held until next verify
            for (int k = 0; k < (shortChal ? 4 : 8); k++) rq.push_back(chal[63-8*k -: 8]);
            rq.push_back(8'h90);
            rq.push_back(8'h00);
          end
          epc_pkg::INS_VERIFY: begin
            ok = cb[5] == epc_pkg::HDR_BYTE;  // identity decrypt
            for (int k = 0; k < 8; k++) ok &= cb[6+k] == refPin[63-8*k -: 8] && cb[14+k] == chal[63-8*k -: 8];
            if (!ok)
              tries = tries - 4'h1;
            rq.push_back(ok ? 8'h90 : 8'h63);
            rq.push_back(ok ? 8'h00 : {4'hC, tries});
          end
          epc_pkg::INS_GENERATE: begin
            txnCnt = txnCnt + 16'h0001;  // counter goes into the stand-in mac
            // stand-in mac: first terminal bytes plus card counter
            for (int k = 5; k < 11; k++) rq.push_back(cb[k]);
            rq.push_back(txnCnt[15:8]);
            rq.push_back(txnCnt[7:0]);
            rq.push_back(8'h90);
            rq.push_back(8'h00);
          end
          default: cmdErr = 1'b1;
        endcase
        n = 0;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// top bench: terminal controller against card model and loopback engines
// assumes rsa engine is identity and tdes answers the inverted block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [4:0] objs;  // cert, exp, rem needed, rem seen, auth key
    logic [7:0] peMod;
    logic [7:0] dynMod;
    logic pinOk;
    logic [1:0] sel;
    logic pass;
    logic [7:0] len;
  } epc_row_t;
  localparam logic [63:0] REF_PIN = 64'h241234FFFFFFFFFF;
  logic clk = 1'b0, reset_n = 1'b0, pinStart = 1'b0, genStart = 1'b0, arcStart = 1'b0;
  logic peCertSeen = 1'b0, peExpSeen = 1'b0, peRemNeeded = 1'b0, peRemSeen = 1'b0;
  logic dynKeySeen = 1'b0, shortChal = 1'b0, rngValid = 1'b1, rsaInReady = 1'b0;
  logic rsaOutValid = 1'b0, rsaOutLast = 1'b0, tdesDone = 1'b0;
  logic [7:0] peModLen = 8'h00, dynModLen = 8'h00, rngByte = 8'h00, rsaOutByte = 8'h00;
  logic [63:0] pinBlock = 64'h0, tdesResult = 64'h0, refPin = REF_PIN;
  logic [231:0] genData = 232'h0;
  logic [15:0] responseCode = 16'h0000;
  logic pinDone, pinPass, genDone, genOk, arcDone, cmdValid, cmdLast, cmdReady, cmdErr;
  logic rspValid, rspLast, rngTake, rsaInValid, rsaInLast, rsaOutReady, tdesValid, tk;
  logic [3:0] triesLeft, expTries = 4'h0, cardTries = 4'h3;
  logic [1:0] keySel;
  logic [7:0] cmdByte, rspByte, rsaInByte;
  logic [63:0] requestCryptogram, responseCryptogram, tdesBlock;
  logic [8:0] oq [$];
  logic [7:0] cap [$];
  epc_row_t rows [0:6];
  int corruptIdx = -1, tdesCnt = 0, mismatches = 0, n_compared = 0;
  epc_terminal_ctrl u_epc_terminal_ctrl (.*);
  epc_card_model u_epc_card_model (.*);
  always #2 clk = ~clk;
  // loopback secure engine, random source and tdes engine
  always @(posedge clk) begin
    tk = rngTake;
    if (rsaInValid && rsaInReady) begin
      cap.push_back(rsaInByte);
      oq.push_back({rsaInLast, rsaInByte ^ ((cap.size() - 1 == corruptIdx) ? 8'h01 : 8'h00)});
    end
    if (rsaOutValid && rsaOutReady)
      void'(oq.pop_front());
    #0.5;
    rsaInReady = ~rsaInReady;  // back-pressure every other cycle
    rngValid = ~rngValid;  // pad source stalls as well
    rsaOutValid = oq.size() > 0;
    {rsaOutLast, rsaOutByte} = rsaOutValid ? oq[0] : ~{rsaOutLast, rsaOutByte};
    if (tk)
      rngByte = rngByte + 8'h01;
    tdesCnt = tdesValid ? tdesCnt + 1 : 0;
    tdesDone = tdesCnt == 4;
    tdesResult = ~tdesBlock;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic pulse_wait(input int which);
    int i;
    logic [2:0] dn;
    @(posedge clk);
    #0.5;
    {arcStart, genStart, pinStart} = 3'b001 << which;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk);
      #0.5;
      {pinStart, genStart, arcStart} = 3'b000;
      dn = {arcDone, genDone, pinDone};
      if (dn[which] === 1'b1)
        break;
    end
    if (i == 3000) begin
      mismatches++;
      complete_run();
    end
  endtask
  initial begin
    rows = '{'{5'b11000, 8'h20, 8'h18, 1'b1, epc_pkg::KEY_PIN_ENC, 1'b1, 8'h20},
      '{5'b11101, 8'h20, 8'h18, 1'b1, epc_pkg::KEY_DYN_AUTH, 1'b1, 8'h18},
      '{5'b11110, 8'h20, 8'h18, 1'b1, epc_pkg::KEY_PIN_ENC, 1'b1, 8'h20},
      '{5'b01001, 8'h20, 8'h11, 1'b1, epc_pkg::KEY_DYN_AUTH, 1'b1, 8'h11},
      '{5'b00000, 8'h20, 8'h18, 1'b1, epc_pkg::KEY_NONE, 1'b0, 8'h00},
      '{5'b00001, 8'h20, 8'h10, 1'b1, epc_pkg::KEY_NONE, 1'b0, 8'h00},
      '{5'b11000, 8'h20, 8'h18, 1'b0, epc_pkg::KEY_PIN_ENC, 1'b0, 8'h20}};
    repeat (5) @(posedge clk);
    #0.5;
    reset_n = 1'b1;
    @(posedge clk);
    #0.5;
    check({pinDone, pinPass, keySel, cmdValid, rsaInValid, tdesValid}, 64'h0);
    foreach (rows[r]) begin
      {peCertSeen, peExpSeen, peRemNeeded, peRemSeen, dynKeySeen} = rows[r].objs;
      peModLen = rows[r].peMod;
      dynModLen = rows[r].dynMod;
      pinBlock = rows[r].pinOk ? REF_PIN : ~REF_PIN;
      cap.delete();
      pulse_wait(0);
      if (!rows[r].pass && rows[r].len != 8'h00) begin
        cardTries = cardTries - 4'h1;
        expTries = cardTries;
      end
      check(64'(keySel), 64'(rows[r].sel));
      check(64'(pinPass), 64'(rows[r].pass));
      check(64'(triesLeft), 64'(expTries));
      check(64'(cap.size()), 64'(rows[r].len));
      if (cap.size() > 8)
        check({cap[0], cap[1], cap[2], cap[3], cap[4], cap[5], cap[6], cap[7]}, {8'h7F, pinBlock[63:8]});
    end
    // corrupt header, then the challenge field: card must refuse both
    pinBlock = REF_PIN;
    for (int c = 0; c < 2; c++) begin
      corruptIdx = c * 9;
      cap.delete();
      pulse_wait(0);
      cardTries = cardTries - 4'h1;
      expTries = cardTries;
      check(64'(pinPass), 64'h0);
      check(64'(triesLeft), 64'(expTries));
    end
    corruptIdx = -1;
    // short challenge answer: method fails before any encipherment
    shortChal = 1'b1;
    cap.delete();
    pulse_wait(0);
    check(64'(pinPass), 64'h0);
    check(64'(cap.size()), 64'h0);
    shortChal = 1'b0;
    pulse_wait(0);
    check(64'(pinPass), 64'h1);
    genData = {48'hA1B2C3D4E5F6, 176'h0, 8'h7E};
    pulse_wait(1);
    check(64'(genOk), 64'h1);
    check(requestCryptogram, {48'hA1B2C3D4E5F6, 16'h0001});
    responseCode = 16'h3030;
    pulse_wait(2);
    check(responseCryptogram, ~({16'h3030, 48'h0} ^ {48'hA1B2C3D4E5F6, 16'h0001}));
    check(64'(cmdErr), 64'h0);
    reset_n = 1'b0;
    @(posedge clk);
    #0.5;
    reset_n = 1'b1;
    @(posedge clk);
    #0.5;
    check({pinPass, triesLeft, genOk}, 64'h0);
    complete_run();
  end
endmodule
`default_nettype wire
